// file: design/prr_readout.sv
// Pace detection and respiration result registers with their serial readout.
// Assumes pace_active, pace_peak, resp and frame inputs come from logic on clock,
// and that sclk, cs_n and sdi are pins from the host, sampled here.
`timescale 1ns/100ps
`include "prr_consts.svh"
// Operation
// - A channel's detected flag sets on the trailing edge of its pace pulse.
// - Flag one means a pulse was seen in the frame, zero means none.
// - Three-bit width field holds log2 of width minus one, reset zero.
// - Width code N means a pulse of two to N plus one samples.
// - Four-bit height field holds log2 of pulse height, reset zero.
// - Respiration magnitude is a 24-bit unsigned value in bits 23 to 0.
// - Respiration phase is 24 bits, full scale is one turn.
// - At the fast rate in frame mode each word goes as two halves.
// - In register read mode the full 32-bit word is returned.
// - Phase never appears in the frame; host must read it explicitly.
module prr_readout (
   input wire logic clock, // 100 MHz system clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable; all state holds while low.
   input wire logic frame_mode, // High: stream frames on the serial port.
   input wire logic rate_128k, // High: fast sample rate selected.
   input wire logic frame_start, // One-cycle pulse: a new frame begins.
   input wire logic [2:0] pace_active, // Per channel: pace pulse in progress.
   input wire logic [47:0] pace_peak, // Per channel: 16-bit pulse height in LSB.
   input wire logic resp_load, // One-cycle pulse: new respiration result.
   input wire prr_pkg::prr_data_t resp_mag, // Respiration magnitude.
   input wire prr_pkg::prr_data_t resp_phase, // Respiration phase.
   input wire logic sclk, // Serial clock pin from the host.
   input wire logic cs_n, // Serial select pin, active low.
   input wire logic sdi, // Serial data in.
   output logic sdo // Serial data out.
);
   import prr_pkg::*;

   // ------------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ------------------------------------------------------------------
   logic [2:0] sync1_q, sync1_d, sync2_q, sync2_d;
   logic sclk_d_q, sclk_d_d, cs_d_q, cs_d_d;
   logic sclk_rise, sclk_fall, cs_fall, sel, sdi_s;

   // Two flops on every pin; the edge detectors look only at the second.
   always_comb begin
      sync1_d = {sclk, cs_n, sdi};
      sync2_d = sync1_q;
      sclk_d_d = sync2_q[2];
      cs_d_d = sync2_q[1];
   end

   // Registers only.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 3'h2;
         sync2_q <= 3'h2;
         sclk_d_q <= 1'b0;
         cs_d_q <= 1'b1;
      end else if (ce) begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         sclk_d_q <= sclk_d_d;
         cs_d_q <= cs_d_d;
      end
   end

   assign sclk_rise = sync2_q[2] && !sclk_d_q;
   assign sclk_fall = !sync2_q[2] && sclk_d_q;
   assign cs_fall = !sync2_q[1] && cs_d_q;
   assign sel = !sync2_q[1];
   assign sdi_s = sync2_q[0];

   // ------------------------------------------------------------------
   // Sample tick and pace accumulation
   // ------------------------------------------------------------------
   logic [9:0] tick_cnt_q, tick_cnt_d;
   logic tick;
   logic [2:0] act_q, act_d;
   logic [8:0] dur_q [3];
   logic [8:0] dur_d [3];
   prr_data_t acc_q, acc_d, pace_rd_q, pace_rd_d, mag_q, mag_d, phase_q, phase_d;

   assign tick = tick_cnt_q == 10'(`PRR_SAMPLE_CYC - 1);

   // Durations count sample ticks; a trailing edge writes flag, width and height.
   always_comb begin
      tick_cnt_d = tick ? 10'h000 : tick_cnt_q + 10'h001;
      act_d = pace_active;
      dur_d = dur_q;
      acc_d = acc_q;
      pace_rd_d = pace_rd_q;
      mag_d = mag_q;
      phase_d = phase_q;
      if (frame_start) begin
         pace_rd_d = acc_q; // The finished frame is what the host sees.
         acc_d = `PRR_PACE_RST;
      end
      for (int c = 0; c < 3; c++) begin
         if (pace_active[c] && !act_q[c]) begin
            dur_d[c] = 9'h000;
         end else if (pace_active[c] && tick && dur_q[c] != 9'h1FF) begin
            dur_d[c] = dur_q[c] + 9'h001;
         end
         // Applied after the clear, so a pulse ending at a frame start is kept.
         if (act_q[c] && !pace_active[c]) begin
            acc_d[c * `PRR_CH_STRIDE + `PRR_DET_POS] = 1'b1;
            acc_d[c * `PRR_CH_STRIDE + `PRR_WID_LSB +: 3] = prr_wid_code(dur_q[c]);
            acc_d[c * `PRR_CH_STRIDE + `PRR_HGT_LSB +: 4] =
               4'(prr_log2({8'h00, pace_peak[c * 16 +: 16]}));
         end
      end
      if (resp_load) begin
         mag_d = resp_mag;
         phase_d = resp_phase;
      end
   end

   // Registers only.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_q <= 10'h000;
         act_q <= 3'h0;
         dur_q[0] <= 9'h000;
         dur_q[1] <= 9'h000;
         dur_q[2] <= 9'h000;
         acc_q <= `PRR_PACE_RST;
         pace_rd_q <= `PRR_PACE_RST;
         mag_q <= `PRR_RESP_RST;
         phase_q <= `PRR_RESP_RST;
      end else if (ce) begin
         tick_cnt_q <= tick_cnt_d;
         act_q <= act_d;
         dur_q <= dur_d;
         acc_q <= acc_d;
         pace_rd_q <= pace_rd_d;
         mag_q <= mag_d;
         phase_q <= phase_d;
      end
   end

   // ------------------------------------------------------------------
   // Frame builder and buffer source
   // ------------------------------------------------------------------
   prr_fb_state_t fb_state_q, fb_state_d;
   logic fb_valid;
   prr_word_t fb_word, pace_w, mag_w;
   logic resp_pend_q, resp_pend_d;
   logic resp_lo_q, resp_lo_d;
   prr_word_t resp_word_q, resp_word_d;
   prr_stream_if buf_in ();
   prr_stream_if buf_out ();

   assign pace_w = {1'b0, `PRR_ADDR_PACE, pace_rd_q};
   assign mag_w = {1'b0, `PRR_ADDR_RMAG, mag_q};

   // The frame carries pace then magnitude; phase is left out on purpose.
   always_comb begin
      fb_state_d = fb_state_q;
      fb_valid = 1'b1;
      fb_word = 32'h00000000;
      unique case (fb_state_q)
         FB_IDLE: begin
            fb_valid = 1'b0;
            if (frame_start && frame_mode) begin
               fb_state_d = FB_PACE_HI;
            end
         end
         FB_PACE_HI: begin
            fb_word = prr_half(pace_w, 1'b0, rate_128k);
            if (buf_in.ready) begin
               fb_state_d = rate_128k ? FB_PACE_LO : FB_MAG_HI;
            end
         end
         FB_PACE_LO: begin
            fb_word = prr_half(pace_w, 1'b1, rate_128k);
            if (buf_in.ready) begin
               fb_state_d = FB_MAG_HI;
            end
         end
         FB_MAG_HI: begin
            fb_word = prr_half(mag_w, 1'b0, rate_128k);
            if (buf_in.ready) begin
               fb_state_d = rate_128k ? FB_MAG_LO : FB_IDLE;
            end
         end
         FB_MAG_LO: begin
            fb_word = prr_half(mag_w, 1'b1, rate_128k);
            if (buf_in.ready) begin
               fb_state_d = FB_IDLE;
            end
         end
         default: begin
            fb_valid = 1'b0;
            fb_state_d = FB_IDLE;
         end
      endcase
   end

   // Frame words go first; a pending read answer waits behind them.
   assign buf_in.valid = fb_valid || resp_pend_q;
   // A split answer goes out as its upper half, then its lower half.
   assign buf_in.data = fb_valid ? fb_word : prr_half(resp_word_q, resp_lo_q,
                                                      frame_mode && rate_128k);

   prr_fifo2 u_buf (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .wr(buf_in),
      .rd(buf_out)
   );

   // ------------------------------------------------------------------
   // Serial shifter and command decode
   // ------------------------------------------------------------------
   prr_word_t tx_q, tx_d, rx_q, rx_d;
   logic [5:0] tx_cnt_q, tx_cnt_d, tx_len_q, tx_len_d, rx_cnt_q, rx_cnt_d;
   logic sdo_q, sdo_d, pop, cmd_done;
   logic tx_hold_q, tx_hold_d;
   prr_data_t rd_data;

   // Input shifts on sclk rising, output on sclk falling; words reload from the buffer.
   always_comb begin
      tx_d = tx_q;
      tx_cnt_d = tx_cnt_q;
      tx_len_d = tx_len_q;
      rx_d = rx_q;
      rx_cnt_d = rx_cnt_q;
      pop = 1'b0;
      cmd_done = 1'b0;
      tx_hold_d = tx_hold_q;
      if (cs_fall) begin
         tx_len_d = (frame_mode && rate_128k) ? `PRR_LEN_HALF : `PRR_LEN_FULL;
         tx_cnt_d = 6'h00;
         rx_cnt_d = 6'h00;
         tx_hold_d = 1'b0;
         // A word taken at the last edge of the previous select has not gone out yet.
         if (!tx_hold_q) begin
            pop = buf_out.valid;
            tx_d = buf_out.valid ? buf_out.data : 32'h00000000;
         end
      end else if (sel && sclk_rise) begin
         rx_d = {rx_q[30:0], sdi_s};
         rx_cnt_d = rx_cnt_q + 6'h01;
         if (rx_cnt_q == 6'h1F) begin
            cmd_done = 1'b1;
            rx_cnt_d = 6'h00;
         end
      end else if (sel && sclk_fall) begin
         tx_cnt_d = tx_cnt_q + 6'h01;
         tx_d = {tx_q[30:0], 1'b0};
         tx_hold_d = 1'b0;
         if (tx_cnt_q == tx_len_q - 6'h01) begin
            tx_cnt_d = 6'h00;
            pop = buf_out.valid;
            tx_d = buf_out.valid ? buf_out.data : 32'h00000000;
            tx_hold_d = buf_out.valid;
         end
      end
      sdo_d = tx_d[31];
      unique case (rx_d[30:24])
         `PRR_ADDR_PACE: rd_data = pace_rd_q;
         `PRR_ADDR_RMAG: rd_data = mag_q;
         `PRR_ADDR_RPHASE: rd_data = phase_q; // Reachable only by a read.
         default: rd_data = 24'h000000;
      endcase
      resp_pend_d = resp_pend_q;
      resp_lo_d = resp_lo_q;
      resp_word_d = resp_word_q;
      if (!fb_valid && resp_pend_q && buf_in.ready) begin
         if (frame_mode && rate_128k && !resp_lo_q) begin
            resp_lo_d = 1'b1;
         end else begin
            resp_pend_d = 1'b0;
            resp_lo_d = 1'b0;
         end
      end
      // A new read wins over the hand-off of the previous answer.
      if (cmd_done && !rx_d[31]) begin
         resp_pend_d = 1'b1;
         resp_lo_d = 1'b0;
         resp_word_d = {1'b0, rx_d[30:24], rd_data};
      end
   end

   assign buf_out.ready = pop;

   // Registers only.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fb_state_q <= FB_IDLE;
         resp_pend_q <= 1'b0;
         resp_lo_q <= 1'b0;
         tx_hold_q <= 1'b0;
         resp_word_q <= 32'h00000000;
         tx_q <= 32'h00000000;
         tx_cnt_q <= 6'h00;
         tx_len_q <= `PRR_LEN_FULL;
         rx_q <= 32'h00000000;
         rx_cnt_q <= 6'h00;
         sdo_q <= 1'b0;
      end else if (ce) begin
         fb_state_q <= fb_state_d;
         resp_pend_q <= resp_pend_d;
         resp_lo_q <= resp_lo_d;
         tx_hold_q <= tx_hold_d;
         resp_word_q <= resp_word_d;
         tx_q <= tx_d;
         tx_cnt_q <= tx_cnt_d;
         tx_len_q <= tx_len_d;
         rx_q <= rx_d;
         rx_cnt_q <= rx_cnt_d;
         sdo_q <= sdo_d;
      end
   end

   assign sdo = sdo_q;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   trail_sets_a: assert property (@(posedge clock) disable iff (!rst_n)
      ce && act_q[1] && !pace_active[1] |=> acc_q[15]) else $error("flag not set");
   lead_no_set_a: assert property (@(posedge clock) disable iff (!rst_n)
      ce && !frame_start && pace_active[0] && !act_q[0] && !acc_q[7] |=> !acc_q[7])
      else $error("flag set on leading edge");
   width_code_a: assert property (@(posedge clock) disable iff (!rst_n)
      ce && act_q[1] && !pace_active[1] && dur_q[1][8:3] == 6'h01 |=> acc_q[14:12] == 3'h2)
      else $error("wrong width code");
   height_code_a: assert property (@(posedge clock) disable iff (!rst_n)
      ce && act_q[0] && !pace_active[0] && pace_peak[15:0] == 16'h0100
      |=> acc_q[3:0] == 4'h8) else $error("wrong height code");
   frame_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
      ce && frame_start && !(act_q[0] && !pace_active[0]) |=> acc_q[7:0] == 8'h00
      && pace_rd_q == $past(acc_q)) else $error("frame did not clear or latch");
   half_len_a: assert property (@(posedge clock) disable iff (!rst_n)
      ce && cs_fall && frame_mode && rate_128k |=> tx_len_q == `PRR_LEN_HALF)
      else $error("split length wrong");
   full_len_a: assert property (@(posedge clock) disable iff (!rst_n)
      ce && cs_fall && !frame_mode |=> tx_len_q == `PRR_LEN_FULL)
      else $error("full length wrong");
   no_phase_a: assert property (@(posedge clock) disable iff (!rst_n)
      fb_state_q == FB_PACE_HI || fb_state_q == FB_MAG_HI |-> fb_word[30:24]
      != `PRR_ADDR_RPHASE) else $error("phase in frame");
   phase_read_a: assert property (@(posedge clock) disable iff (!rst_n)
      ce && cmd_done && !rx_d[31] && rx_d[30:24] == `PRR_ADDR_RPHASE
      |=> resp_pend_q && resp_word_q[23:0] == $past(phase_q)) else $error("phase read");
   mag_read_a: assert property (@(posedge clock) disable iff (!rst_n)
      ce && cmd_done && !rx_d[31] && rx_d[30:24] == `PRR_ADDR_RMAG
      |=> resp_word_q == {1'b0, `PRR_ADDR_RMAG, $past(mag_q)}) else $error("mag read");

endmodule : prr_readout

// file: design/prr_consts.svh
// Constants of the pace and respiration result readout: addresses, field positions,
// reset values, word lengths and timing counts.
// Assumes it is included by bare name wherever one of these macros is used.
`ifndef PRR_CONSTS_SVH
`define PRR_CONSTS_SVH

// ------------------------------------------------------------------
// Register addresses on the serial interface
// ------------------------------------------------------------------
`define PRR_ADDR_PACE 7'h1A
`define PRR_ADDR_RMAG 7'h1B
`define PRR_ADDR_RPHASE 7'h1C

// ------------------------------------------------------------------
// Pace field layout; channel c starts at bit c times the stride
// ------------------------------------------------------------------
`define PRR_CH_STRIDE 8
`define PRR_DET_POS 7
`define PRR_WID_LSB 4
`define PRR_HGT_LSB 0
`define PRR_PACE_RST 24'h000000
`define PRR_RESP_RST 24'h000000

// ------------------------------------------------------------------
// Serial word lengths and buffer depth
// ------------------------------------------------------------------
`define PRR_LEN_HALF 6'h10
`define PRR_LEN_FULL 6'h20
`define PRR_BUF_DEPTH 2

// ------------------------------------------------------------------
// Timing: sample rate in kHz and system clock in kHz
// ------------------------------------------------------------------
`define PRR_SAMPLE_KHZ 128
`define PRR_CLK_KHZ 100000
`define PRR_SAMPLE_CYC (`PRR_CLK_KHZ / `PRR_SAMPLE_KHZ)

`endif

// file: design/prr_pkg.sv
// Types and helper functions of the pace and respiration result readout.
// Assumes nothing of its surroundings.
package prr_pkg;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef logic [23:0] prr_data_t;
   typedef logic [31:0] prr_word_t;

   typedef enum logic [2:0] {
      FB_IDLE = 3'b000,
      FB_PACE_HI = 3'b001,
      FB_PACE_LO = 3'b010,
      FB_MAG_HI = 3'b011,
      FB_MAG_LO = 3'b100
   } prr_fb_state_t;

   // ------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------
   // Position of the highest set bit; zero for a zero value.
   function automatic logic [4:0] prr_log2(input logic [23:0] v);
      logic [4:0] l;
      l = 5'h00;
      for (int i = 0; i < 24; i++) begin
         if (v[i]) begin
            l = 5'(i);
         end
      end
      return l;
   endfunction : prr_log2

   // Width code: log2 of the duration in samples, minus one, floored at zero.
   function automatic logic [2:0] prr_wid_code(input logic [8:0] d);
      logic [4:0] l;
      l = prr_log2({15'h0000, d});
      return (l == 5'h00) ? 3'h0 : 3'(l - 5'h01);
   endfunction : prr_wid_code

   // Picks the whole word, its upper half or its lower half, left aligned.
   function automatic prr_word_t prr_half(input prr_word_t w, input logic lo,
                                          input logic split);
      if (lo) begin
         return {w[15:0], 16'h0000};
      end
      return split ? {w[31:16], 16'h0000} : w;
   endfunction : prr_half

endpackage : prr_pkg

// file: design/prr_stream_if.sv
// Valid/ready word stream between the readout and its output buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface prr_stream_if;
   logic valid;
   logic ready;
   logic [31:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : prr_stream_if

// file: design/prr_fifo2.sv
// Two-entry word buffer between the frame and answer sources and the serial shifter.
// Assumes a single clock, an active-low asynchronous reset and a freezing clock enable.
`timescale 1ns/100ps
`include "prr_consts.svh"
module prr_fifo2 (
   input wire logic clock, // System clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable; state holds while low.
   prr_stream_if.snk wr, // Filling side.
   prr_stream_if.src rd // Draining side.
);
   logic [31:0] mem_q [2];
   logic [31:0] mem_d [2];
   logic wp_q, wp_d, rp_q, rp_d;
   logic [1:0] cnt_q, cnt_d;
   logic push, take;

   // ------------------------------------------------------------------
   // Pointer and storage update
   // ------------------------------------------------------------------
   // Storage is written at the write index; the count tracks both sides.
   always_comb begin
      push = wr.valid && wr.ready;
      take = rd.valid && rd.ready;
      mem_d = mem_q;
      if (push) begin
         mem_d[wp_q] = wr.data;
      end
      wp_d = wp_q ^ push;
      rp_d = rp_q ^ take;
      cnt_d = cnt_q + {1'b0, push} - {1'b0, take};
   end

   // Registers only.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mem_q[0] <= 32'h00000000;
         mem_q[1] <= 32'h00000000;
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
      end else if (ce) begin
         mem_q <= mem_d;
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   // Full and empty come straight from the count.
   assign wr.ready = cnt_q != 2'(`PRR_BUF_DEPTH);
   assign rd.valid = cnt_q != 2'h0;
   assign rd.data = mem_q[rp_q];

   count_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
      cnt_q <= 2'(`PRR_BUF_DEPTH)) else $error("buffer count above depth");
   fill_full_a: assert property (@(posedge clock) disable iff (!rst_n)
      ce && cnt_q == 2'h1 && push && !take |=> !wr.ready && rd.valid)
      else $error("buffer did not report full");

endmodule : prr_fifo2

// file: tb/prr_host_model.sv
// Host side of the serial register port: drives select, serial clock and data in.
// Assumes the device samples sdi on rising sclk and moves sdo after falling sclk.
`timescale 1ns/100ps
module prr_host_model (
   output logic sclk, // Serial clock, idle low.
   output logic cs_n, // Select, active low.
   output logic sdi, // Serial data to the device.
   input wire logic sdo // Serial data from the device.
);
   // ------------------------------------------------------------------
   // Idle levels
   // ------------------------------------------------------------------
   // The serial clock stands still while not selected.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end

   // ------------------------------------------------------------------
   // Transfer
   // ------------------------------------------------------------------
   // One select period of n bits at 80 ns; sdo is taken late in the high phase.
   task automatic xfer(input logic [31:0] cmd, input int n, output logic [63:0] rx);
      logic [63:0] sh;
      sh = {cmd, 32'h00000000};
      rx = 64'h0000000000000000;
      #3.3;
      cs_n = 1'b0;
      sdi = sh[63];
      #80;
      for (int i = 0; i < n; i++) begin
         sclk = 1'b1;
         #39;
         rx = {rx[62:0], sdo};
         #1;
         sclk = 1'b0;
         sh = {sh[62:0], 1'b0};
         sdi = sh[63];
         #40;
      end
      cs_n = 1'b1;
      sdi = ~sdi; // A released line shows the inverse of its last value.
      #120;
   endtask : xfer
endmodule : prr_host_model

// file: tb/prr_readout_tb.sv
// Self-checking bench of the pace and respiration result readout.
// Assumes the host model on the serial pins and a 100 MHz clock.
`timescale 1ns/100ps
`include "prr_consts.svh"
module prr_readout_tb;
   import prr_pkg::*;
   logic clock, rst_n, frame_mode, rate_128k, frame_start, resp_load;
   logic [2:0] pace_active;
   logic [47:0] pace_peak;
   prr_data_t resp_mag, resp_phase;
   logic sclk, cs_n, sdi, sdo;
   logic [63:0] rx;
   prr_data_t ph [3] = '{24'h400000, 24'h800000, 24'hC00000};
   int n_fail = 0;
   int check_count = 0;

   // ------------------------------------------------------------------
   // Clock, design and host
   // ------------------------------------------------------------------
   // Free-running 100 MHz clock.
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   prr_readout dut_u (.clock(clock), .rst_n(rst_n), .ce(1'b1), .frame_mode(frame_mode),
      .rate_128k(rate_128k), .frame_start(frame_start), .pace_active(pace_active),
      .pace_peak(pace_peak), .resp_load(resp_load), .resp_mag(resp_mag),
      .resp_phase(resp_phase), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

   prr_host_model host_u (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   // Compares a shifted-out result.
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Waits n edges, then steps just past the edge.
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc

   // Read command, then an ignored write whose slot carries the answer.
   task automatic rd(input logic [6:0] a, output logic [63:0] r);
      host_u.xfer({1'b0, a, 24'h000000}, 32, r);
      host_u.xfer(32'h80000000, 32, r);
   endtask : rd

   // One-cycle frame start pulse.
   task automatic fs();
      frame_start = 1'b1;
      cyc(1);
      frame_start = 1'b0;
      cyc(2);
   endtask : fs

   // Prints the counts and the verdict, then stops.
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish

   // ------------------------------------------------------------------
   // Watchdog
   // ------------------------------------------------------------------
   // Cuts a hang short well beyond the expected run of about 30000 cycles.
   initial begin
      repeat (60000) @(posedge clock);
      n_fail++;
      $display("watchdog expired at %0t", $time);
      tally_and_finish();
   end

   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   // Reset values, read-only registers, respiration, pace and frame packing.
   initial begin
      static logic [6:0] adr [4] = '{`PRR_ADDR_PACE, `PRR_ADDR_RMAG, `PRR_ADDR_RPHASE, 7'h05};
      {frame_mode, rate_128k, frame_start, resp_load, pace_active} = 7'h00;
      pace_peak = {16'h0003, 16'h8000, 16'h0100};
      resp_mag = 24'h000000;
      resp_phase = 24'h000000;
      rst_n = 1'b0;
      repeat (12) @(posedge clock);
      #1;
      rst_n = 1'b1;
      cyc(3);
      host_u.xfer({1'b1, `PRR_ADDR_RMAG, 24'hFFFFFF}, 32, rx);
      foreach (adr[i]) begin
         rd(adr[i], rx);
         chk(rx, {32'h00000000, 1'b0, adr[i], 24'h000000});
      end
      // The precise pace registers live outside this block, so their address reads zero.
      rd(7'h3A, rx);
      chk(rx, {32'h00000000, 1'b0, 7'h3A, 24'h000000});
      $display("test reset_values finished");
      for (int i = 0; i < 3; i++) begin
         resp_mag = 24'hA5C3E1 ^ 24'(i);
         resp_phase = ph[i];
         resp_load = 1'b1;
         cyc(1);
         resp_load = 1'b0;
         cyc(2);
         rd(`PRR_ADDR_RMAG, rx);
         chk(rx, {32'h00000000, 1'b0, `PRR_ADDR_RMAG, resp_mag});
         rd(`PRR_ADDR_RPHASE, rx);
         chk(rx, {32'h00000000, 1'b0, `PRR_ADDR_RPHASE, ph[i]});
      end
      $display("test respiration finished");
      // Pulses of 3, 12 and 24 samples; a frame starts while all are still high.
      for (int t = 0; t < 24 * `PRR_SAMPLE_CYC + 4; t++) begin
         pace_active[0] = (t < 3 * `PRR_SAMPLE_CYC);
         pace_active[1] = (t < 12 * `PRR_SAMPLE_CYC);
         pace_active[2] = (t < 24 * `PRR_SAMPLE_CYC);
         frame_start = (t == 100);
         cyc(1);
      end
      rd(`PRR_ADDR_PACE, rx);
      chk(rx, {32'h00000000, 1'b0, `PRR_ADDR_PACE, 24'h000000});
      fs();
      rd(`PRR_ADDR_PACE, rx);
      // Widths 0, 2, 3 and heights 8, 15, 1 with all three flags set.
      chk(rx, {32'h00000000, 1'b0, `PRR_ADDR_PACE, 24'hB1AF88});
      $display("test pace finished");
      // Fast frame: pace then magnitude in halves, the answer after them, no phase.
      frame_mode = 1'b1;
      rate_128k = 1'b1;
      cyc(2);
      fs();
      host_u.xfer(32'h80000000, 16, rx);
      chk(rx, {48'h000000000000, 1'b0, `PRR_ADDR_PACE, 8'h00});
      host_u.xfer({1'b0, `PRR_ADDR_RPHASE, 24'h000000}, 32, rx);
      chk(rx, {48'h000000000000, 1'b0, `PRR_ADDR_RMAG, resp_mag[23:16]});
      host_u.xfer(32'h80000000, 48, rx);
      chk(rx, {16'h0000, resp_mag[15:0], 1'b0, `PRR_ADDR_RPHASE, ph[2]});
      host_u.xfer(32'h80000000, 16, rx);
      chk(rx, 64'h0000000000000000);
      $display("test fast_frame finished");
      // Register read at the fast rate outside frame mode returns the whole word.
      frame_mode = 1'b0;
      cyc(2);
      rd(`PRR_ADDR_RMAG, rx);
      chk(rx, {32'h00000000, 1'b0, `PRR_ADDR_RMAG, resp_mag});
      $display("test fast_read finished");
      tally_and_finish();
   end
endmodule : prr_readout_tb
